// File: rtl/fdc_pkg.sv
// package for the fluorescent display configuration block
// assumes a 4-bit processor data path with a nibble/byte write port
package fdc_pkg;
  // register addresses in the processor data memory space
  localparam logic [11:0] FDC_ADDR_DIMMER      = 12'hf89;
  localparam logic [11:0] FDC_ADDR_DIGIT_COUNT = 12'hf8a;
  localparam logic [11:0] FDC_ADDR_HIGH_STATIC = 12'hfd4;
  localparam logic [11:0] FDC_ADDR_LOW_STATIC  = 12'hfd6;
  // reset values
  localparam logic [3:0]  FDC_RST_DIMMER       = 4'h0;
  localparam logic [3:0]  FDC_RST_DIGIT_COUNT  = 4'h8;
  localparam logic [7:0]  FDC_RST_STATIC       = 8'h00;
  // field positions
  localparam int          FDC_CYCLE_LEN_BIT    = 0;
  localparam int          FDC_CUT_LSB          = 1;
  localparam int          FDC_LOW_STATIC_LSB   = 0;
  localparam int          FDC_HIGH_STATIC_LSB  = 4;
  localparam logic [7:0]  FDC_LOW_STATIC_MASK  = 8'h0f;
  localparam logic [7:0]  FDC_HIGH_STATIC_MASK = 8'h30;
  // display cycle lengths in main oscillator periods
  localparam int          FDC_CYCLE_SHORT      = 1024;
  localparam int          FDC_CYCLE_LONG       = 2048;
  localparam int          FDC_SIXTEENTH_SHORT  = FDC_CYCLE_SHORT / 16;
  localparam int          FDC_SIXTEENTH_LONG   = FDC_CYCLE_LONG / 16;
  // extra slots per period beyond the digit count value (key scan slot etc.)
  localparam int          FDC_PERIOD_EXTRA     = 2;
  // scan state
  typedef enum logic [1:0] {
    FDC_IDLE = 2'b01,
    FDC_SCAN = 2'b10
  } fdc_state_e;
endpackage

// File: rtl/fdc_cut_table.sv
// cut-width table: maps the 3-bit cut code to a count of sixteenths
// assumes nothing but a combinational code input
`timescale 1ns/100ps
`default_nettype none
module fdc_cut_table
  import fdc_pkg::*;
(
  input  wire logic [2:0] cut_code,
  output logic      [3:0] cut_sixteenths
);
  // code 0 is one sixteenth, every other code is twice its value
  assign cut_sixteenths = (cut_code == 3'h0) ? 4'h1 : {cut_code, 1'b0};
endmodule
`default_nettype wire

// File: rtl/fdc_top.sv
// fluorescent display scanner configuration and digit timing
// assumes cpu writes arrive synchronous to clk_sys, one write per strobe
//
// Function
// - scanned digits equal digit count value plus one.
// - reset loads digit count with binary 1000, nine digits.
// - digit count and dimmer accept only whole nibble writes.
// - display cycle is 1024 periods when bit zero, 2048 when one.
// - cut width code removes 1,2,4,...,14 sixteenths of each digit pulse.
// - reset clears dimmer register: short cycle, smallest cut.
// - low static field zero: low segment pins driven dynamically.
// - low static field ones: low segments output port latches 12-15.
// - high static bits zero: high segments driven dynamically.
// - high static bits ones: high segments output port latches 10, 11.
// - static registers are byte writes, cleared at reset.
// - full period is display cycle times digit count plus two.
// - scanning runs only while display enable is one.
// - digit pulse width varies over eight levels from cut width.
`timescale 1ns/100ps
`default_nettype none
module fdc_top
  import fdc_pkg::*;
#(
  parameter int DIGITS_MAX = 16
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // processor data memory port
  input  wire logic [11:0]           cpu_addr,
  input  wire logic                  cpu_wr_nib,
  input  wire logic                  cpu_wr_byte,
  input  wire logic [7:0]            cpu_wdata,
  input  wire logic                  cpu_rd,
  output logic      [7:0]            cpu_rdata,
  // display configuration inputs from the mode register outside this block
  input  wire logic                  display_enable_bit,
  input  wire logic [2:0]            segment_count_sel,
  // dynamic segment data from the display data fetch
  input  wire logic [15:0]           dyn_low_seg,
  input  wire logic [7:0]            dyn_high_seg,
  // port latches used for static output
  input  wire logic [15:0]           port_latch_12_15,
  input  wire logic [7:0]            port_latch_10_11,
  // display pins
  output logic      [15:0]           low_segment_pins,
  output logic      [7:0]            high_segment_pins,
  output logic      [DIGITS_MAX-1:0] digit_pins,
  // scan status
  output logic      [4:0]            scan_slot,
  output logic                       cycle_start
);
  logic             rst_meta_b;
  logic             rst_sync_b;
  logic [3:0]       dimmer_cycle_select;
  logic [3:0]       digit_count_select;
  logic [7:0]       high_segment_static_select;
  logic [7:0]       low_segment_static_select;
  logic             act_long;
  logic [2:0]       act_cut;
  logic [3:0]       act_digits;
  logic [10:0]      cyc_cnt;
  logic [4:0]       slot;
  fdc_state_e       state;
  fdc_state_e       next_state;
  logic [3:0]       cut_sixteenths;
  logic [10:0]      seg_len;
  logic [10:0]      cycle_last;
  logic [11:0]      cut_len;
  logic [10:0]      on_len;
  logic             cyc_end;
  logic             slot_end;
  logic             pulse_on;
  logic             low_static;
  logic             high_static;
  logic             wr_dimmer;
  logic             wr_digits;
  logic             wr_high;
  logic             wr_low;
  logic [DIGITS_MAX-1:0] next_digit;
  logic             hit_dimmer;
  logic             hit_digits;
  logic             hit_high;
  logic             hit_low;
  logic [3:0]       next_dimmer;
  logic [3:0]       next_digit_count;
  logic [7:0]       next_high_static;
  logic [7:0]       next_low_static;
  logic [7:0]       rd_mux;
  logic [7:0]       next_rdata;
  logic             scan_live;
  logic             load_set;
  logic [10:0]      next_cyc_cnt;
  logic [4:0]       next_slot;
  logic             next_act_long;
  logic [2:0]       next_act_cut;
  logic [3:0]       next_act_digits;
  logic [15:0]      low_dyn_mask;
  logic [15:0]      next_low_seg;
  logic [7:0]       next_high_seg;
  logic             next_cycle_start;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // address hits shared by the write strobes and the read multiplexer
  assign hit_dimmer = (cpu_addr == FDC_ADDR_DIMMER);
  assign hit_digits = (cpu_addr == FDC_ADDR_DIGIT_COUNT);
  assign hit_high   = (cpu_addr == FDC_ADDR_HIGH_STATIC);
  assign hit_low    = (cpu_addr == FDC_ADDR_LOW_STATIC);

  // byte writes to the nibble registers are ignored rather than truncated
  assign wr_dimmer = cpu_wr_nib && hit_dimmer;
  assign wr_digits = cpu_wr_nib && hit_digits;
  assign wr_high   = cpu_wr_byte && hit_high;
  assign wr_low    = cpu_wr_byte && hit_low;

  assign next_dimmer      = wr_dimmer ? cpu_wdata[3:0] : dimmer_cycle_select;
  assign next_digit_count = wr_digits ? cpu_wdata[3:0] : digit_count_select;
  // spare static bits are masked on the way in, so they can never read back
  assign next_high_static = wr_high ? (cpu_wdata & FDC_HIGH_STATIC_MASK) : high_segment_static_select;
  assign next_low_static  = wr_low ? (cpu_wdata & FDC_LOW_STATIC_MASK) : low_segment_static_select;

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dimmer_cycle_select <= FDC_RST_DIMMER;
      digit_count_select  <= FDC_RST_DIGIT_COUNT;
    end else begin
      dimmer_cycle_select <= next_dimmer;
      digit_count_select  <= next_digit_count;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      high_segment_static_select <= FDC_RST_STATIC;
      low_segment_static_select  <= FDC_RST_STATIC;
    end else begin
      high_segment_static_select <= next_high_static;
      low_segment_static_select  <= next_low_static;
    end
  end

  // read data registered and held between reads; unmapped addresses read zero
  assign rd_mux     = hit_dimmer ? {4'h0, dimmer_cycle_select} :
                      hit_digits ? {4'h0, digit_count_select} :
                      hit_high   ? high_segment_static_select :
                      hit_low    ? low_segment_static_select :
                      8'h00;
  assign next_rdata = cpu_rd ? rd_mux : cpu_rdata;

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cpu_rdata <= 8'h00;
    end else begin
      cpu_rdata <= next_rdata;
    end
  end

  fdc_cut_table u_cut (
    .cut_code       (act_cut),
    .cut_sixteenths (cut_sixteenths)
  );

  // timing derived from the settings latched at the cycle start
  assign seg_len    = act_long ? 11'(FDC_SIXTEENTH_LONG) : 11'(FDC_SIXTEENTH_SHORT);
  assign cycle_last = act_long ? 11'(FDC_CYCLE_LONG - 1) : 11'(FDC_CYCLE_SHORT - 1);
  assign cut_len    = 12'(seg_len * cut_sixteenths);
  assign on_len     = 11'(12'(cycle_last) + 12'h001 - cut_len);
  assign cyc_end    = (cyc_cnt == cycle_last);
  // period covers digit count plus two cycles; last slot is blank
  assign slot_end   = cyc_end && (slot == 5'(act_digits) + 5'(FDC_PERIOD_EXTRA - 1));
  assign pulse_on   = (cyc_cnt < on_len) && (slot <= 5'(act_digits));

  assign next_state = display_enable_bit ? FDC_SCAN : FDC_IDLE;

  // halting drops the counters, the digit pins and the dynamic segment pins at once, so a re-enable starts a fresh period
  assign scan_live    = (state == FDC_SCAN) && display_enable_bit;
  assign next_cyc_cnt = (scan_live && !cyc_end) ? cyc_cnt + 11'h001 : 11'h000;
  assign next_slot    = !scan_live ? 5'h00 :
                        !cyc_end   ? slot :
                        slot_end   ? 5'h00 :
                        slot + 5'h01;

  // settings are sampled only between display cycles, so no digit is split
  assign load_set        = (state == FDC_IDLE) || (scan_live && cyc_end);
  assign next_act_long   = load_set ? dimmer_cycle_select[FDC_CYCLE_LEN_BIT] : act_long;
  assign next_act_cut    = load_set ? dimmer_cycle_select[FDC_CUT_LSB +: 3] : act_cut;
  assign next_act_digits = load_set ? digit_count_select : act_digits;

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= FDC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cyc_cnt <= 11'h000;
      slot    <= 5'h00;
    end else begin
      cyc_cnt <= next_cyc_cnt;
      slot    <= next_slot;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      act_long   <= FDC_RST_DIMMER[FDC_CYCLE_LEN_BIT];
      act_cut    <= FDC_RST_DIMMER[FDC_CUT_LSB +: 3];
      act_digits <= FDC_RST_DIGIT_COUNT;
    end else begin
      act_long   <= next_act_long;
      act_cut    <= next_act_cut;
      act_digits <= next_act_digits;
    end
  end

  always_comb begin
    next_digit = '0;
    if (scan_live && pulse_on && (slot < 5'(DIGITS_MAX))) begin
      next_digit[slot[3:0]] = 1'b1;
    end
  end

  assign low_static  = &low_segment_static_select[FDC_LOW_STATIC_LSB +: 4];
  assign high_static = &high_segment_static_select[FDC_HIGH_STATIC_LSB +: 2];

  // segment count widens the dynamic field beyond nine pins
  assign low_dyn_mask     = 16'hffff >> (4'h7 - {1'b0, segment_count_sel});
  // static outputs ignore display enable; dynamic outputs blank when halted
  assign next_low_seg     = low_static ? port_latch_12_15 :
                            (scan_live && pulse_on) ? (dyn_low_seg & low_dyn_mask) :
                            16'h0000;
  assign next_high_seg    = high_static ? port_latch_10_11 :
                            (scan_live && pulse_on) ? dyn_high_seg :
                            8'h00;
  assign next_cycle_start = scan_live && (cyc_cnt == 11'h000);

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      low_segment_pins  <= 16'h0000;
      high_segment_pins <= 8'h00;
    end else begin
      low_segment_pins  <= next_low_seg;
      high_segment_pins <= next_high_seg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      digit_pins  <= '0;
      scan_slot   <= 5'h00;
      cycle_start <= 1'b0;
    end else begin
      digit_pins  <= next_digit;
      scan_slot   <= slot;
      cycle_start <= next_cycle_start;
    end
  end
endmodule
`default_nettype wire

// File: sim/fdc_checker.sv
// port assertions for the display configuration block
// assumes a single clk_sys domain and the async active-low rst_b of fdc_top
`timescale 1ns/100ps
`default_nettype none
module fdc_checker
  import fdc_pkg::*;
#(
  parameter int DIGITS_MAX = 16
) (
  input wire logic                  clk_sys,
  input wire logic                  rst_b,
  input wire logic [11:0]           cpu_addr,
  input wire logic                  cpu_wr_byte,
  input wire logic [7:0]            cpu_wdata,
  input wire logic                  cpu_rd,
  input wire logic [7:0]            cpu_rdata,
  input wire logic                  display_enable_bit,
  input wire logic [15:0]           port_latch_12_15,
  input wire logic [7:0]            port_latch_10_11,
  input wire logic [15:0]           low_segment_pins,
  input wire logic [7:0]            high_segment_pins,
  input wire logic [DIGITS_MAX-1:0] digit_pins,
  input wire logic                  cycle_start
);
  logic [11:0] cs_cnt;
  logic [11:0] pw;
  logic        seen;
  logic        low_st;
  logic        high_st;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // shadow of the static selects; mixed settings count as dynamic
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cs_cnt <= 12'h000;
      pw <= 12'h000;
      seen <= 1'b0;
      low_st <= 1'b0;
      high_st <= 1'b0;
    end else begin
      cs_cnt <= cycle_start ? 12'h001 : cs_cnt + 12'h001;
      pw <= (|digit_pins) ? pw + 12'h001 : 12'h000;
      seen <= display_enable_bit & (seen | cycle_start);
      low_st <= (cpu_wr_byte && cpu_addr == FDC_ADDR_LOW_STATIC) ? &cpu_wdata[3:0] : low_st;
      high_st <= (cpu_wr_byte && cpu_addr == FDC_ADDR_HIGH_STATIC) ? &cpu_wdata[5:4] : high_st;
    end
  end
  sequence s_rd(logic [11:0] a);
    cpu_rd && cpu_addr == a;
  endsequence
  low_spare_a: assert property (s_rd(FDC_ADDR_LOW_STATIC) |=> (cpu_rdata & ~FDC_LOW_STATIC_MASK) == 8'h00)
    else $error("low static spare bits not zero");
  high_spare_a: assert property (s_rd(FDC_ADDR_HIGH_STATIC) |=> (cpu_rdata & ~FDC_HIGH_STATIC_MASK) == 8'h00)
    else $error("high static spare bits not zero");
  digit_nibble_a: assert property (s_rd(FDC_ADDR_DIGIT_COUNT) |=> cpu_rdata[7:4] == 4'h0)
    else $error("digit count read wider than a nibble");
  digit_onehot_a: assert property ($onehot0(digit_pins))
    else $error("more than one digit active");
  idle_dark_a: assert property (!display_enable_bit ##1 !display_enable_bit |-> !(|digit_pins) && !cycle_start)
    else $error("scan active while disabled");
  cycle_len_a: assert property (cycle_start && seen |-> cs_cnt == 12'h400 || cs_cnt == 12'h800)
    else $error("display cycle length wrong");
  pulse_grid_a: assert property (pw != 12'h000 && !(|digit_pins) && display_enable_bit && $past(display_enable_bit)
    |-> pw[5:0] == 6'h00 && pw <= 12'h780)
    else $error("digit pulse width off the cut grid");
  low_static_a: assert property (low_st |=> low_segment_pins == $past(port_latch_12_15))
    else $error("low pins not following port latch");
  high_static_a: assert property (high_st |=> high_segment_pins == $past(port_latch_10_11))
    else $error("high pins not following port latch");
endmodule
bind fdc_top fdc_checker #(.DIGITS_MAX(DIGITS_MAX)) u_fdc_checker (
  .clk_sys(clk_sys), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_wr_byte(cpu_wr_byte), .cpu_wdata(cpu_wdata),
  .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .display_enable_bit(display_enable_bit),
  .port_latch_12_15(port_latch_12_15), .port_latch_10_11(port_latch_10_11), .low_segment_pins(low_segment_pins),
  .high_segment_pins(high_segment_pins), .digit_pins(digit_pins), .cycle_start(cycle_start)
);
`default_nettype wire

// File: sim/fdc_tube_model.sv
// passive tube model: last digit pulse width, digits and segments lit since clear
// assumes sixteen grid lines sampled on clk_sys
`timescale 1ns/100ps
`default_nettype none
module fdc_tube_model (
  input  wire logic        clk_sys,
  input  wire logic        clr,
  input  wire logic [15:0] digit_pins,
  input  wire logic [15:0] low_seg,
  input  wire logic [7:0]  high_seg,
  output logic      [11:0] width,
  output logic      [15:0] lit,
  output logic      [23:0] seg_seen
);
  logic [11:0] run = 12'h000;
  always @(posedge clk_sys) begin
    run <= (|digit_pins) ? run + 12'h001 : 12'h000;
    if (!(|digit_pins) && run != 12'h000) begin
      width <= run;
    end
    lit <= clr ? 16'h0000 : (lit | digit_pins);
    // a segment only glows under a lit grid, so only those are collected
    seg_seen <= clr ? 24'h000000 : (seg_seen | ((|digit_pins) ? {high_seg, low_seg} : 24'h000000));
  end
endmodule
`default_nettype wire

// File: sim/test_fluorescent_display_config.sv
// bench for the display configuration block: registers, static pins, digit timing
// assumes fdc_tube_model on the grid lines and fdc_checker bound to fdc_top
`timescale 1ns/100ps
`default_nettype none
module test_fluorescent_display_config
  import fdc_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [11:0] cpu_addr = 12'h000;
  logic        cpu_wr_nib = 1'b0;
  logic        cpu_wr_byte = 1'b0;
  logic [7:0]  cpu_wdata = 8'h00;
  logic        cpu_rd = 1'b0;
  logic        en = 1'b0;
  logic        clr = 1'b1;
  logic [15:0] latch_lo = 16'h0000;
  logic [7:0]  latch_hi = 8'h00;
  logic [2:0]  seg_sel = 3'h0;
  logic [7:0]  cpu_rdata;
  logic [7:0]  high_pins;
  logic [15:0] low_pins;
  logic [15:0] digits;
  logic [15:0] lit;
  logic [23:0] seg_seen;
  logic [15:0] exp;
  logic [11:0] width;
  logic        cs;
  int          err_count = 0;
  int          compares = 0;
  always #5 clk_sys = ~clk_sys;
  fdc_top #(.DIGITS_MAX(16)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_wr_nib(cpu_wr_nib), .cpu_wr_byte(cpu_wr_byte),
    .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .display_enable_bit(en),
    .segment_count_sel(seg_sel), .dyn_low_seg(16'hffff), .dyn_high_seg(8'hff), .port_latch_12_15(latch_lo),
    .port_latch_10_11(latch_hi), .low_segment_pins(low_pins), .high_segment_pins(high_pins),
    .digit_pins(digits), .scan_slot(), .cycle_start(cs));
  fdc_tube_model tube (.clk_sys(clk_sys), .clr(clr), .digit_pins(digits), .low_seg(low_pins), .high_seg(high_pins),
    .width(width), .lit(lit), .seg_seen(seg_seen));
  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    compares++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic is_byte);
    tick(1);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr_byte = is_byte;
    cpu_wr_nib = ~is_byte;
    tick(1);
    cpu_wr_byte = 1'b0;
    cpu_wr_nib = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] want);
    tick(1);
    cpu_addr = a;
    cpu_rd = 1'b1;
    tick(1);
    cpu_rd = 1'b0;
    chk({8'h00, cpu_rdata}, {8'h00, want});
  endtask
  // bounded wait for n cycle-start pulses; a hang ends the run as a failure
  task automatic wait_cs(input int n);
    int i;
    repeat (n) begin
      i = 0;
      do begin
        tick(1);
        i++;
      end while (cs !== 1'b1 && i < 2200);
      if (i >= 2200) begin
        err_count++;
        $display("unexpected at %0t: no cycle start", $time);
        report_and_stop();
      end
    end
  endtask
  initial begin
    tick(10);
    rst_b = 1'b1;
    tick(4);
    rd(FDC_ADDR_DIMMER, 8'h00);
    rd(FDC_ADDR_DIGIT_COUNT, 8'h08);
    rd(FDC_ADDR_HIGH_STATIC, 8'h00);
    rd(FDC_ADDR_LOW_STATIC, 8'h00);
    wr(FDC_ADDR_DIMMER, 8'h0b, 1'b1);
    wr(FDC_ADDR_LOW_STATIC, 8'hff, 1'b0);
    rd(FDC_ADDR_DIMMER, 8'h00);
    rd(FDC_ADDR_LOW_STATIC, 8'h00);
    rd(12'h123, 8'h00);
    latch_lo = 16'ha5c3;
    latch_hi = 8'h96;
    wr(FDC_ADDR_LOW_STATIC, 8'hff, 1'b1);
    wr(FDC_ADDR_HIGH_STATIC, 8'hff, 1'b1);
    rd(FDC_ADDR_LOW_STATIC, 8'h0f);
    rd(FDC_ADDR_HIGH_STATIC, 8'h30);
    chk(low_pins, 16'ha5c3);
    chk({8'h00, high_pins}, 16'h0096);
    en = 1'b1;
    latch_lo = 16'h3c5a;
    tick(3);
    chk(low_pins, 16'h3c5a);
    wr(FDC_ADDR_LOW_STATIC, 8'h00, 1'b1);
    wr(FDC_ADDR_HIGH_STATIC, 8'h00, 1'b1);
    // four cycle starts: the last completed pulse ran on the new setting even past a blank slot
    for (int k = 0; k < 8; k++) begin
      wr(FDC_ADDR_DIMMER, {4'h0, k[2:0], 1'b0}, 1'b0);
      wait_cs(4);
      exp = (k == 0) ? 16'h03c0 : 16'h0400 - {k[8:0], 7'h00};
      chk({4'h0, width}, exp);
    end
    wr(FDC_ADDR_DIMMER, 8'h0f, 1'b0);
    wait_cs(4);
    chk({4'h0, width}, 16'h0100);
    wr(FDC_ADDR_DIMMER, 8'h00, 1'b0);
    wait_cs(2);
    clr = 1'b0;
    wait_cs(11);
    chk(lit, 16'h01ff);
    chk(seg_seen[15:0], 16'h01ff);
    chk({8'h00, seg_seen[23:16]}, 16'h00ff);
    wr(FDC_ADDR_DIGIT_COUNT, 8'h0f, 1'b0);
    rd(FDC_ADDR_DIGIT_COUNT, 8'h0f);
    wait_cs(2);
    clr = 1'b1;
    seg_sel = 3'h7;
    tick(1);
    clr = 1'b0;
    wait_cs(18);
    chk(lit, 16'hffff);
    chk(seg_seen[15:0], 16'hffff);
    en = 1'b0;
    tick(3);
    chk(digits, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
